// ===== srmrs_ctrl.sv
/*
 * controller side of the memory reset and mode-register set flow: drives
 * reset, clock enable, termination and command/address pins of the device.
 * assumes the user holds the device idle (banks precharged, bursts done)
 * before asking for a single mode-register rewrite.
 */
`timescale 1ns/1ns
`include "srmrs_defs.svh"

// Notes on behaviour
// - hold device reset low at least the minimum reset pulse width.
// - drive clock enable low at least 10 ns before releasing reset.
// - after reset release repeat the whole power-on initialization flow.
// - issue deselect in every idle cycle between mode writes and before ZQCL.
// - write every mode register that has defined settings during initialization.
// - write order free except dependencies; DLL enable before DLL reset.
// - keep the test mode enable pin low throughout.
// - mode register defaults undefined; write all after every reset.
// - every mode write drives all fields of the addressed register.
// - wait at least tMRD between two consecutive mode writes.
// - input-changing mode writes use their own delay instead of tMRD; the code waits TMRD_CYC after every init write but the last.
// - wait tMOD after a mode write before any non-MRS, non-DES command.
// - slow-updating mode writes use their own longer delay instead of tMOD.
// - rewrite a mode register in normal operation only when the device is idle.
// - with nominal termination enabled keep ODT low before the mode write; the code forces ODT low only from the mode write cycle on.
// - with termination enabled, raise ODT again only after tMOD.
// - with termination disabled, ODT level around a mode write is free.
// - bank group, bank, A17, A13..A0 carry mode register bits 21..0.
// - RAS_n, CAS_n and WE_n are all low during a mode write.
// - wait 500 us, at most three seconds, after reset before clock enable.
// - run the clock 10 ns or five periods, deselect at clock enable rise.
// - wait tXPR after clock enable high before the first mode write.
// - load MR3, MR6, MR5, MR4, MR2, MR1, MR0 then ZQCL.
module srmrs_ctrl #(
	parameter int unsigned POST_RESET_CYC = `SRMRS_POST_RESET_CYC,
	parameter int unsigned RESET_PW_CYC   = `SRMRS_RESET_PW_CYC,
	parameter int unsigned TXPR_CYC       = `SRMRS_TXPR_CYC,
	parameter int unsigned TMRD_CYC       = `SRMRS_TMRD_CYC,
	parameter int unsigned TMOD_CYC       = `SRMRS_TMOD_CYC,
	parameter int unsigned ZQ_CYC         = `SRMRS_ZQ_CYC,
	parameter int unsigned SLOW_CYC       = `SRMRS_TMOD_CYC
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// user control
	input  wire logic                    init_start,
	input  wire logic                    mr_write,
	input  wire logic [2:0]              mr_write_index,
	input  wire logic                    mr_slow,
	input  wire logic                    rtt_nom_on,
	input  wire logic                    odt_request,
	input  wire logic [`SRMRS_MR_W-1:0]  mr_value [`SRMRS_MR_COUNT],
	// user status
	output logic                         busy,
	output logic                         ready,
	// memory pins
	output logic                         reset_n,
	output logic                         cke,
	output logic                         cs_n,
	output logic                         act_n,
	output logic                         ras_n,
	output logic                         cas_n,
	output logic                         we_n,
	output logic                         odt,
	output logic                         test_mode_enable_pin,
	output logic [1:0]                   bg,
	output logic [1:0]                   ba,
	output logic [17:0]                  addr
);
	import srmrs_pkg::*;

	// ============================================================
	// constants
	// ============================================================
	localparam int unsigned CW = 32;
	localparam int unsigned STABLE_CYC =
		(`SRMRS_CLK_STABLE_CYC > `SRMRS_CLK_STABLE_MIN) ?
		`SRMRS_CLK_STABLE_CYC : `SRMRS_CLK_STABLE_MIN;
	localparam int unsigned LEAD_CYC = (`SRMRS_CKE_LEAD_CYC > 0) ? `SRMRS_CKE_LEAD_CYC : 1;

	// ============================================================
	// state
	// ============================================================
	srmrs_state_type state;
	srmrs_state_type next_state;
	logic [CW-1:0]   count;
	logic [CW-1:0]   next_count;
	logic [2:0]      step;
	logic [2:0]      next_step;
	logic            single;
	logic            next_single;
	logic            slow;
	logic            next_slow;
	logic            odt_hold;
	logic            next_odt_hold;
	logic [2:0]      cur_index;
	logic [2:0]      next_cur_index;

	// init order MR3, MR6, MR5, MR4, MR2, MR1, MR0 keeps DLL enable before reset
	function automatic logic [2:0] srmrs_order(input logic [2:0] s);
		unique case (s)
			3'h0: srmrs_order = 3'h3;
			3'h1: srmrs_order = 3'h6;
			3'h2: srmrs_order = 3'h5;
			3'h3: srmrs_order = 3'h4;
			3'h4: srmrs_order = 3'h2;
			3'h5: srmrs_order = 3'h1;
			default: srmrs_order = 3'h0;
		endcase
	endfunction : srmrs_order

	// ============================================================
	// sequencer
	// ============================================================
	always_comb begin
		next_state    = state;
		next_count    = (count != '0) ? count - CW'(1) : '0;
		next_step     = step;
		next_single   = single;
		next_slow     = slow;
		next_odt_hold = odt_hold;
		next_cur_index = cur_index;
		unique case (state)
			SRMRS_IDLE: begin
				if (init_start) begin
					next_state = SRMRS_RESET;
					next_count = CW'(RESET_PW_CYC);
				end
			end
			SRMRS_RESET: begin
				if (count == '0) begin
					next_state = SRMRS_CKE_LEAD;
					next_count = CW'(LEAD_CYC);
				end
			end
			SRMRS_CKE_LEAD: begin
				if (count == '0) begin
					next_state = SRMRS_POST_RESET;
					next_count = CW'(POST_RESET_CYC);
				end
			end
			SRMRS_POST_RESET: begin
				if (count == '0) begin
					next_state = SRMRS_CLK_STABLE;
					next_count = CW'(STABLE_CYC);
				end
			end
			SRMRS_CLK_STABLE: begin
				if (count == '0) begin
					next_state = SRMRS_XPR;
					next_count = CW'(TXPR_CYC);
					next_step  = '0;
				end
			end
			SRMRS_XPR: begin
				if (count == '0) begin
					next_state  = SRMRS_MRS;
					next_single = 1'b0;
				end
			end
			SRMRS_MRS: begin
				next_state = SRMRS_WAIT;
				// slow writes wait SLOW_CYC, any other last write of a sequence tMOD, others tMRD
				if (slow) begin
					next_count = CW'(SLOW_CYC - 1);
				end else if (single || step == `SRMRS_LAST_STEP) begin
					next_count = CW'(TMOD_CYC - 1);
				end else begin
					next_count = CW'(TMRD_CYC - 1);
				end
			end
			SRMRS_WAIT: begin
				if (count == '0) begin
					if (single) begin
						next_state    = SRMRS_READY;
						next_odt_hold = 1'b0;
					end else if (step == `SRMRS_LAST_STEP) begin
						next_state = SRMRS_ZQ;
					end else begin
						next_state = SRMRS_MRS;
						next_step  = step + 3'h1;
					end
				end
			end
			SRMRS_ZQ: begin
				next_state = SRMRS_ZQ_WAIT;
				next_count = CW'(ZQ_CYC - 1);
			end
			SRMRS_ZQ_WAIT: begin
				if (count == '0) begin
					next_state    = SRMRS_READY;
					next_odt_hold = 1'b0;
				end
			end
			SRMRS_READY: begin
				if (init_start) begin
					next_state    = SRMRS_RESET;
					next_count    = CW'(RESET_PW_CYC);
					next_odt_hold = 1'b1;
				end else if (mr_write) begin
					// user vouches device is idle; cke already high
					next_state    = SRMRS_MRS;
					next_single   = 1'b1;
					next_slow     = mr_slow;
					next_cur_index = mr_write_index;
					next_odt_hold = rtt_nom_on;
				end
			end
			default: next_state = SRMRS_IDLE;
		endcase
		if (state == SRMRS_IDLE && init_start) begin
			next_odt_hold = 1'b1;
		end
		if (state == SRMRS_XPR) begin
			next_slow = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state    <= SRMRS_IDLE;
			count    <= '0;
			step     <= '0;
			single   <= 1'b0;
			slow     <= 1'b0;
			odt_hold <= 1'b1;
			cur_index <= '0;
		end else begin
			state    <= next_state;
			count    <= next_count;
			step     <= next_step;
			single   <= next_single;
			slow     <= next_slow;
			odt_hold <= next_odt_hold;
			cur_index <= next_cur_index;
		end
	end

	// ============================================================
	// pin drivers, all registered from the next state
	// ============================================================
	logic                   pin_reset_n;
	logic                   pin_cke;
	srmrs_cmd_type          pin_cmd;
	logic [`SRMRS_MR_W-1:0] pin_mr;
	logic [2:0]             pin_index;

	always_comb begin
		pin_reset_n = !(next_state == SRMRS_RESET || next_state == SRMRS_CKE_LEAD);
		pin_cke     = !(next_state inside {SRMRS_IDLE, SRMRS_RESET, SRMRS_CKE_LEAD,
			SRMRS_POST_RESET, SRMRS_CLK_STABLE});
		pin_cmd     = SRMRS_CMD_DES;
		pin_index   = (next_single || state == SRMRS_READY) ?
			((state == SRMRS_READY) ? mr_write_index : cur_index) :
			srmrs_order(next_step);
		pin_mr      = mr_value[pin_index];
		if (next_state == SRMRS_MRS) begin
			pin_cmd = SRMRS_CMD_MRS;
		end else if (next_state == SRMRS_ZQ) begin
			pin_cmd = SRMRS_CMD_ZQCL;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reset_n <= 1'b1;
			cke     <= 1'b0;
			cs_n    <= 1'b1;
			act_n   <= 1'b1;
			ras_n   <= 1'b1;
			cas_n   <= 1'b1;
			we_n    <= 1'b1;
			odt     <= 1'b0;
			test_mode_enable_pin <= 1'b0;
			bg      <= '0;
			ba      <= '0;
			addr    <= '0;
			busy    <= 1'b0;
			ready   <= 1'b0;
		end else begin
			reset_n <= pin_reset_n;
			cke     <= pin_cke;
			cs_n    <= (pin_cmd == SRMRS_CMD_DES);
			act_n   <= 1'b1;
			ras_n   <= (pin_cmd != SRMRS_CMD_MRS);
			cas_n   <= (pin_cmd != SRMRS_CMD_MRS);
			we_n    <= 1'b0;
			odt     <= !next_odt_hold && odt_request;
			test_mode_enable_pin <= 1'b0;
			if (pin_cmd == SRMRS_CMD_MRS) begin
				// select bits come from the index so a stale value cannot misroute
				bg       <= {pin_mr[`SRMRS_MR_BANK_HI], pin_index[2]};
				ba       <= pin_index[1:0];
				addr     <= {pin_mr[`SRMRS_MR_A17], 3'h0, pin_mr[`SRMRS_MR_ALO_HI:0]};
			end else if (pin_cmd == SRMRS_CMD_ZQCL) begin
				bg   <= '0;
				ba   <= '0;
				addr <= 18'h00400; // A10 high selects long calibration
			end else begin
				bg   <= '0;
				ba   <= '0;
				addr <= '0;
			end
			busy  <= (next_state != SRMRS_IDLE && next_state != SRMRS_READY);
			ready <= (next_state == SRMRS_READY);
		end
	end
endmodule : srmrs_ctrl

// ===== srmrs_defs.svh
/*
 * timing counts and field positions for the memory reset and mode-register
 * set sequencer. assumes a 10 MHz controller clock (100 ns period).
 */
`ifndef SRMRS_DEFS_SVH
`define SRMRS_DEFS_SVH

// ============================================================
// clock and times
// ============================================================
`define SRMRS_CLK_PERIOD_NS     100
`define SRMRS_CKE_LEAD_NS       10
`define SRMRS_CKE_LEAD_CYC      ((`SRMRS_CKE_LEAD_NS + `SRMRS_CLK_PERIOD_NS - 1) / `SRMRS_CLK_PERIOD_NS)
`define SRMRS_POST_RESET_US     500
`define SRMRS_POST_RESET_CYC    ((`SRMRS_POST_RESET_US * 1000 + `SRMRS_CLK_PERIOD_NS - 1) / `SRMRS_CLK_PERIOD_NS)
`define SRMRS_CLK_STABLE_NS     10
`define SRMRS_CLK_STABLE_MIN    5
`define SRMRS_CLK_STABLE_CYC    ((`SRMRS_CLK_STABLE_NS + `SRMRS_CLK_PERIOD_NS - 1) / `SRMRS_CLK_PERIOD_NS)
`define SRMRS_RESET_PW_CYC      2
`define SRMRS_TXPR_CYC          5
`define SRMRS_TMRD_CYC          8
`define SRMRS_TMOD_CYC          24
`define SRMRS_ZQ_CYC            1024

// ============================================================
// mode register layout
// ============================================================
`define SRMRS_MR_W              22
`define SRMRS_MR_BANK_HI        21
`define SRMRS_MR_BANK_LO        18
`define SRMRS_MR_A17            17
`define SRMRS_MR_ALO_HI         13
`define SRMRS_MR_COUNT          7
`define SRMRS_MR0_INDEX         3'h0
`define SRMRS_LAST_STEP         3'h6

`endif

// ===== srmrs_pkg.sv
/*
 * types for the memory reset and mode-register set sequencer.
 * assumes srmrs_defs.svh is available.
 */
package srmrs_pkg;
	// ============================================================
	// sequencer states
	// ============================================================
	typedef enum logic [3:0] {
		SRMRS_IDLE,
		SRMRS_RESET,
		SRMRS_CKE_LEAD,
		SRMRS_POST_RESET,
		SRMRS_CLK_STABLE,
		SRMRS_XPR,
		SRMRS_MRS,
		SRMRS_WAIT,
		SRMRS_ZQ,
		SRMRS_ZQ_WAIT,
		SRMRS_READY
	} srmrs_state_type;

	// command on the memory pins
	typedef enum logic [1:0] {
		SRMRS_CMD_DES,
		SRMRS_CMD_MRS,
		SRMRS_CMD_ZQCL
	} srmrs_cmd_type;
endpackage : srmrs_pkg

// ===== srmrs_ctrl_assertions.sv
/* port checker for the reset and mode-register sequencer.
   assumes it is bound to srmrs_ctrl and sees its ports only. */
`timescale 1ns/1ns
// ========
// checker
// ========
module srmrs_chk #(
	parameter int unsigned POST_RESET_CYC = 10,
	parameter int unsigned TMOD_CYC = 24
) (
	// clock and reset
	input wire logic	clk,
	input wire logic	rst,
	// user side
	input wire logic	init_start,
	input wire logic	rtt_nom_on,
	input wire logic [21:0]	mr_value [7],
	input wire logic	busy,
	// memory pins
	input wire logic	reset_n,
	input wire logic	cke,
	input wire logic	cs_n,
	input wire logic	act_n,
	input wire logic	ras_n,
	input wire logic	cas_n,
	input wire logic	we_n,
	input wire logic	odt,
	input wire logic	test_mode_enable_pin,
	input wire logic [1:0]	bg,
	input wire logic [1:0]	ba,
	input wire logic [17:0]	addr
);
	wire		mrs = !cs_n && !ras_n;
	wire		zq = !cs_n && ras_n;
	wire [2:0]	idx = {bg[0], ba};
	int unsigned	since_mrs, since_rel, next_since_mrs, next_since_rel;
	always_comb begin
		next_since_mrs = (rst || mrs) ? 0 : since_mrs + 1;
		next_since_rel = (rst || !reset_n) ? 0 : since_rel + 1;
	end
	always_ff @(posedge clk) begin
		since_mrs <= next_since_mrs;
		since_rel <= next_since_rel;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_quiet_mrd;
		!mrs [*7];
	endsequence
	sequence s_odt_off;
		!odt [*8];
	endsequence
	chk_test_pin_low: assert property (!test_mode_enable_pin)
		else $error("test pin high");
	chk_mrs_pins: assert property (mrs |-> !cas_n && !we_n && act_n)
		else $error("bad mode write pins");
	chk_mrd_gap: assert property (mrs |=> s_quiet_mrd)
		else $error("mode writes too close");
	chk_xpr_gap: assert property ($rose(cke) |=> !mrs [*5])
		else $error("mode write too soon after clock enable");
	chk_cke_lead: assert property ($rose(reset_n) |-> !cke && !$past(cke))
		else $error("clock enable not low before reset release");
	chk_reset_width: assert property ($fell(reset_n) |-> !reset_n [*2])
		else $error("reset pulse too short");
	chk_post_wait: assert property ($rose(cke) |-> since_rel >= POST_RESET_CYC)
		else $error("clock enable too soon after reset");
	chk_zq_mod: assert property (zq |-> since_mrs >= TMOD_CYC - 1)
		else $error("calibration too soon after mode write");
	chk_odt_quiet: assert property (mrs && rtt_nom_on |-> !$past(odt) ##0 s_odt_off)
		else $error("termination not held low around mode write");
	chk_pin_map: assert property (mrs |-> addr[13:0] == mr_value[idx][13:0] &&
		addr[17] == mr_value[idx][17] && bg[1] == mr_value[idx][21] && addr[16:14] == 3'h0)
		else $error("mode bits mismapped");
	chk_init_go: assert property (init_start && !busy |=> busy && !reset_n)
		else $error("init request not taken");
	chk_des_gap: assert property (mrs |=> cs_n [*7])
		else $error("command between mode writes");
	chk_odt_after_mod: assert property (odt && rtt_nom_on |-> since_mrs >= TMOD_CYC - 1)
		else $error("termination raised before mode delay");
endmodule : srmrs_chk

bind srmrs_ctrl srmrs_chk #(.POST_RESET_CYC(POST_RESET_CYC), .TMOD_CYC(TMOD_CYC)) chk_u (
	.clk, .rst, .init_start, .rtt_nom_on, .mr_value, .busy, .reset_n, .cke, .cs_n,
	.act_n, .ras_n, .cas_n, .we_n, .odt, .test_mode_enable_pin, .bg, .ba, .addr);

// ===== srmrs_dev_model.sv
/* behavioural memory device: keeps the seven mode registers.
   assumes commands are sampled on the rising clock edge. */
`timescale 1ns/1ns
// ========
// device
// ========
module srmrs_dev (
	// clock and device reset
	input wire logic	clk,
	input wire logic	reset_n,
	// command pins
	input wire logic	cke,
	input wire logic	cs_n,
	input wire logic	ras_n,
	input wire logic	cas_n,
	input wire logic	we_n,
	input wire logic [1:0]	bg,
	input wire logic [1:0]	ba,
	input wire logic [17:0]	addr,
	// state seen by the bench
	output logic [21:0]	mr_q [7],
	output logic [6:0]	mr_done,
	output logic		zq_seen
);
	logic [21:0]	next_mr [7];
	logic [6:0]	next_done;
	logic		next_zq;
	// termination is ignored here, so its level never matters
	always_comb begin
		next_mr = mr_q;
		next_done = mr_done;
		next_zq = zq_seen;
		if (!reset_n) begin
			next_mr = '{default: 'x};
			next_done = 7'h00;
			next_zq = 1'b0;
		end else if (cke && !cs_n && !ras_n && !cas_n && !we_n) begin
			next_mr[{bg[0], ba}] = {bg, ba, addr[17], 3'h0, addr[13:0]};
			next_done[{bg[0], ba}] = 1'b1;
		end else if (cke && !cs_n && ras_n && cas_n && !we_n) begin
			next_zq = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		mr_q <= next_mr;
		mr_done <= next_done;
		zq_seen <= next_zq;
	end
endmodule : srmrs_dev

// ===== sdram_reset_and_mode_register_set_tb_top.sv
/* bench for the reset and mode-register sequencer with a device model.
   assumes the checker is bound through its own file. */
`timescale 1ns/1ns
module sdram_reset_and_mode_register_set_tb_top;
	logic		clk = 1'b0;
	logic		rst = 1'b1;
	logic		init_start = 1'b0;
	logic		mr_write = 1'b0;
	logic [2:0]	mr_write_index = 3'h5;
	logic		mr_slow = 1'b0;
	logic		rtt_nom_on = 1'b1;
	logic		odt_request = 1'b0;
	logic [21:0]	mr_value [7] = '{default: 22'h0};
	logic		busy, ready, reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, odt, test_pin;
	logic [1:0]	bg, ba;
	logic [17:0]	addr;
	logic [21:0]	mr_q [7];
	logic [6:0]	mr_done;
	logic		zq_seen;
	logic [2:0]	order [$];
	logic [2:0]	seq_exp [7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
	int		miscompares = 0;
	int		check_count = 0;
	int		cycles = 0;
	// shortened waits keep the run brief; a longer slow delay makes it visible
	localparam int TMOD = 24;
	localparam int SLOW = 40;
	srmrs_ctrl #(.POST_RESET_CYC(10), .ZQ_CYC(8), .TMOD_CYC(TMOD), .SLOW_CYC(SLOW)) dut_u (
		.clk, .rst, .init_start, .mr_write, .mr_write_index, .mr_slow, .rtt_nom_on,
		.odt_request, .mr_value, .busy, .ready, .reset_n, .cke, .cs_n, .act_n, .ras_n,
		.cas_n, .we_n, .odt, .test_mode_enable_pin(test_pin), .bg, .ba, .addr);
	srmrs_dev dev_u (.clk, .reset_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bg, .ba,
		.addr, .mr_q, .mr_done, .zq_seen);
	always #50 clk = ~clk;
	always @(posedge clk)
		if (!rst && !cs_n && !ras_n) order.push_back({bg[0], ba});
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic check_val(input logic [21:0] got, input logic [21:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val
	task automatic step;
		@(posedge clk);
		#10;
	endtask : step
	task automatic wait_ready;
		for (int n = 0; n < 400 && ready !== 1'b1; n++) step();
	endtask : wait_ready
	task automatic check_regs;
		foreach (mr_q[i]) check_val(mr_q[i],
			{mr_value[i][21], 3'(i), mr_value[i][17], 3'h0, mr_value[i][13:0]});
	endtask : check_regs
	// poke asks for a write while busy; it must be dropped
	task automatic t_init(input logic [21:0] base, input logic poke);
		order = {};
		foreach (mr_value[i]) mr_value[i] = base ^ 22'(i * 22'h041041);
		init_start = 1'b1;
		step();
		init_start = 1'b0;
		repeat (3) step();
		check_val(22'(mr_done), 22'h0);
		mr_write = poke;
		step();
		mr_write = 1'b0;
		wait_ready();
		check_val(22'(ready), 22'h1);
		check_val(22'(order.size()), 22'h7);
		foreach (seq_exp[i]) check_val(22'(order[i]), 22'(seq_exp[i]));
		check_regs();
		check_val(22'(zq_seen), 22'h1);
	endtask : t_init
	task automatic t_single(input logic [2:0] idx, input logic rtt, input logic slow);
		int n;
		order = {};
		rtt_nom_on = rtt;
		mr_slow = slow;
		mr_value[idx] = ~mr_value[idx];
		mr_write_index = idx;
		mr_write = 1'b1;
		step();
		mr_write = 1'b0;
		odt_request = 1'b1;
		step();
		check_val(22'(odt), 22'(!rtt));
		for (n = 1; n < 400 && ready !== 1'b1; n++) step();
		check_val(22'(n), 22'(slow ? SLOW + 1 : TMOD + 1));
		check_val(22'(order.size()), 22'h1);
		check_val(22'(order[0]), 22'(idx));
		check_regs();
		repeat (24) step();
		check_val(22'(odt), 22'h1);
		odt_request = 1'b0;
	endtask : t_single
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (20) @(posedge clk);
		#10;
		rst = 1'b0;
		t_init(22'h2A5A5A, 1'b0);
		t_single(3'h2, 1'b1, 1'b0);
		t_single(3'h0, 1'b0, 1'b1);
		t_init(22'h15A3C6, 1'b1);
		report_and_stop();
	end
endmodule : sdram_reset_and_mode_register_set_tb_top
